/* hw/sfps_map.vh */
// Register map, field positions and timing for the secondary fuse sequencer
// Summary of operation
// [RQ1] Autonomous wake to active; burns only when programming
// [RQ2] Page 0 reg program_command_control bit 1 escapes
// [RQ3] Pointer byte 0xff sends slaves to secondary
// [RQ4] Bit 7 of wakeup_mode_select selects manual wake
// [RQ5] Bit 6 zero manual; one removes it
// [RQ6] Burn code in program_command_control burns current page
// [RQ7] Register 0xff selects the active page
// [RQ8] New pointers take effect after reset only
// [RQ9] 0xe0 and 0xe1 force slave power-up
// [RQ10] Lock field 0x2f[7:6]=1 arms page burn
// [RQ11] Host re-escapes, sets bit 6, reburns
// [RQ12] Final boot wakes from secondary fuse data
// [RQ13] Host burns all eight pages in order
// [RQ14] Host changes single bits by read-modify-write
// [RQ15] Burn outside programming or unlocked is ignored; the master page burns here without a lock
`ifndef SFPS_MAP_VH
`define SFPS_MAP_VH

// Register offsets within a page
`define SFPS_ADDR_PGM_CMD   8'h0f
`define SFPS_ADDR_WAKE_SEL  8'h10
`define SFPS_ADDR_PTR       8'h22
`define SFPS_ADDR_LOCK      8'h2f
`define SFPS_ADDR_FORCE0    8'he0
`define SFPS_ADDR_FORCE1    8'he1
`define SFPS_ADDR_PAGE      8'hff

// Page select codes
`define SFPS_PG_MASTER      8'h00
`define SFPS_PG_MONITOR     8'h01
`define SFPS_PG_INPUT       8'h02
`define SFPS_PG_OUTPUT      8'h03
`define SFPS_PG_LOOP_FIRST  8'h0a
`define SFPS_PG_LOOP_LAST   8'h0d

// Field positions and codes
`define SFPS_ESC_BIT        1
`define SFPS_BURN_MSB       7
`define SFPS_BURN_LSB       3
`define SFPS_BURN_CODE      5'h18
`define SFPS_LOCK_MSB       7
`define SFPS_LOCK_LSB       6
`define SFPS_LOCK_CODE      2'h1
`define SFPS_WAKE_MAN_BIT   7
`define SFPS_WAKE_AUTO_BIT  6

// Reset values
`define SFPS_RST_BYTE       8'h00
`define SFPS_RST_PAGE       8'h00

// Timing
`define SFPS_CLK_PERIOD_NS  5
`define SFPS_BURN_TIME_NS   100
`define SFPS_BURN_CYCLES    ((`SFPS_BURN_TIME_NS + `SFPS_CLK_PERIOD_NS - 1) / `SFPS_CLK_PERIOD_NS)

`endif

/* hw/sfps_burn_timer.v */
// Fuse burn pulse timer: busy for a fixed count, then a done pulse
`timescale 1ns/1ps
module sfps_burn_timer #(
  parameter CYCLES = 20,            // Burn duration in clock cycles
  parameter W      = 8              // Counter width
) (
  input  wire clk,                  // System clock
  input  wire srst,                 // Synchronous reset, active high
  input  wire start,                // Start pulse
  output reg  busy,                 // Burn in progress
  output reg  done                  // One-cycle end of burn
);
  localparam [31:0]  LAST_FULL = CYCLES - 1;          // Start count, full width
  localparam [W-1:0] LAST      = LAST_FULL[W-1:0];    // Cut to counter width

  reg [W-1:0] cnt;                  // Remaining cycles

  // Count down; a start while busy is dropped so a pulse is never cut short
  always @(posedge clk) begin
    if (srst) begin
      busy <= 1'b0;
      done <= 1'b0;
      cnt  <= {W{1'b0}};
    end else begin
      done <= 1'b0;
      if (start && !busy) begin     // Arm
        busy <= 1'b1;
        cnt  <= LAST;
      end else if (busy) begin
        if (cnt == {W{1'b0}}) begin // Expired
          busy <= 1'b0;
          done <= 1'b1;
        end else begin
          cnt <= cnt - 1'b1;
        end
      end
    end
  end
endmodule

/* hw/sfps_seq.v */
// Secondary fuse programming sequencer with paged register access
`timescale 1ns/1ps
`include "sfps_map.vh"
module sfps_seq #(
  parameter BURN_CYCLES = `SFPS_BURN_CYCLES // Burn pulse length
) (
  input  wire       CLK_SYS,        // 200 MHz system clock
  input  wire       SRST,           // Chip reset, sync, active high
  input  wire       FUSE_BLANK,     // Erase fuse model, sync, active high
  input  wire       REG_WR,         // Register write strobe
  input  wire       REG_RD,         // Register read strobe
  input  wire [7:0] REG_ADDR,       // Register offset in page
  input  wire [7:0] REG_WDATA,      // Write data
  output reg  [7:0] REG_RDATA,      // Read data
  output reg        REG_RVALID,     // Read data valid pulse
  output reg  [1:0] STATE,          // Sequencer state
  output reg        BURN_BUSY,      // Burn pulse in progress
  output reg        BURN_DONE,      // One-cycle burn complete
  output reg  [7:0] SEC_BURNED,     // Secondary bank burned per page
  output reg  [6:0] SLAVE_SEC_SEL,  // Slave fetches from secondary
  output reg  [6:0] SLAVE_FORCE_ON, // Slave forced power-up
  output reg        MANUAL_WAKE,    // Booted in manual wake mode
  output reg        SEC_BOOT        // Booted autonomously from secondary
);

  // Sequencer states
  localparam [1:0] ST_BOOT   = 2'd0; // Load fuse copies after reset
  localparam [1:0] ST_ACTIVE = 2'd1; // Normal operation
  localparam [1:0] ST_PGM    = 2'd2; // Program-command state
  localparam [1:0] ST_BURN   = 2'd3; // Burn pulse running

  reg [1:0] state;                  // Current state
  reg [7:0] page;                   // Selected page code
  reg [7:0] wake_sel;               // Wake mode register copy
  reg [7:0] fuse_ptr_reg;           // Fuse pointer register copy
  reg [7:0] force0;                 // Force register A
  reg [7:0] force1;                 // Force register B
  reg [7:0] lock_reg [0:7];         // Lock register per page
  reg [2:0] burn_idx;               // Page being burned
  reg [7:0] fuse_wake;              // Fused master wake byte
  reg [7:0] fuse_ptr;               // Fused master pointer byte
  reg [7:0] sec_burned;             // Secondary bank burned flags
  integer   i;                      // Loop index

  wire       t_busy;                // Timer running
  wire       t_done;                // Timer expired
  reg        t_start;               // Timer start pulse

  // Map a page code to {valid, index}
  function [3:0] page_index;
    input [7:0] code;
    begin
      case (code)
        `SFPS_PG_MASTER:  page_index = 4'h8;
        `SFPS_PG_MONITOR: page_index = 4'h9;
        `SFPS_PG_INPUT:   page_index = 4'ha;
        `SFPS_PG_OUTPUT:  page_index = 4'hb;
        8'h0a:            page_index = 4'hc;
        8'h0b:            page_index = 4'hd;
        8'h0c:            page_index = 4'he;
        `SFPS_PG_LOOP_LAST: page_index = 4'hf;
        default:          page_index = 4'h0; // Unknown page
      endcase
    end
  endfunction

  wire [3:0] pidx      = page_index(page);       // Decoded page
  wire       pg_valid  = pidx[3];                // Page code known
  wire [2:0] cur       = pidx[2:0];              // Page index
  wire       on_master = (page == `SFPS_PG_MASTER); // Master page
  wire       wr_ok     = REG_WR && (state != ST_BURN) && (state != ST_BOOT);
  wire       wr_pgm    = wr_ok && (REG_ADDR == `SFPS_ADDR_PGM_CMD);
  wire [7:0] cur_lock  = lock_reg[cur];          // Lock of current page
  wire       lock_ok   = (cur_lock[`SFPS_LOCK_MSB:`SFPS_LOCK_LSB]
                          == `SFPS_LOCK_CODE);   // Page armed
  wire       burn_cmd  = (REG_WDATA[`SFPS_BURN_MSB:`SFPS_BURN_LSB]
                          == `SFPS_BURN_CODE);   // Burn code seen
  // Master page carries no lock step in the sequence, so it is exempt
  wire       burn_go   = wr_pgm && burn_cmd && pg_valid &&
                         (state == ST_PGM) &&
                         (on_master || lock_ok); // RQ15
  wire       esc_go    = wr_pgm && on_master &&
                         REG_WDATA[`SFPS_ESC_BIT] &&
                         (state == ST_ACTIVE);   // RQ2
  // Manual wake needs bit 7 set and bit 6 clear
  wire       man_sel   = fuse_wake[`SFPS_WAKE_MAN_BIT] &&
                         !fuse_wake[`SFPS_WAKE_AUTO_BIT]; // RQ4 RQ5

  // Burn pulse timing lives in its own counter
  sfps_burn_timer #(
    .CYCLES (BURN_CYCLES),
    .W      (13)
  ) u_timer (
    .clk   (CLK_SYS),
    .srst  (SRST),
    .start (t_start),
    .busy  (t_busy),
    .done  (t_done)
  );

  // Control state, page select and volatile registers
  always @(posedge CLK_SYS) begin
    if (SRST) begin
      state        <= ST_BOOT;
      page         <= `SFPS_RST_PAGE;
      wake_sel     <= `SFPS_RST_BYTE;
      fuse_ptr_reg <= `SFPS_RST_BYTE;
      force0       <= `SFPS_RST_BYTE;
      force1       <= `SFPS_RST_BYTE;
      burn_idx     <= 3'd0;
      t_start      <= 1'b0;
      for (i = 0; i < 8; i = i + 1) begin
        lock_reg[i] <= `SFPS_RST_BYTE;
      end
    end else begin
      t_start <= 1'b0;
      case (state)
        ST_BOOT: begin
          // Shadow registers reload from fuse so later edits keep bits
          wake_sel     <= fuse_wake;     // RQ14
          fuse_ptr_reg <= fuse_ptr;      // RQ8
          // Manual wake lands ready for burns; otherwise run normally
          state <= man_sel ? ST_PGM : ST_ACTIVE; // RQ1 RQ12
        end
        ST_ACTIVE: begin
          if (esc_go) begin              // Escape to program state
            state <= ST_PGM;             // RQ2 RQ11
          end
        end
        ST_PGM: begin
          if (burn_go) begin             // Start burn of current page
            state    <= ST_BURN;         // RQ1 RQ6
            burn_idx <= cur;
            t_start  <= 1'b1;
          end
        end
        ST_BURN: begin
          if (t_done) begin              // Burn finished
            state <= ST_PGM;
          end
        end
        default: begin
          state <= ST_BOOT;
        end
      endcase
      // Register writes, refused while booting or burning
      if (wr_ok) begin
        case (REG_ADDR)
          `SFPS_ADDR_PAGE: begin
            page <= REG_WDATA;           // RQ7
          end
          `SFPS_ADDR_WAKE_SEL: begin
            if (on_master) begin
              wake_sel <= REG_WDATA;     // RQ4 RQ5 RQ11
            end
          end
          `SFPS_ADDR_PTR: begin
            if (on_master) begin
              fuse_ptr_reg <= REG_WDATA; // RQ3
            end
          end
          `SFPS_ADDR_FORCE0: begin
            if (on_master) begin
              force0 <= REG_WDATA;       // RQ9
            end
          end
          `SFPS_ADDR_FORCE1: begin
            if (on_master) begin
              force1 <= REG_WDATA;       // RQ9
            end
          end
          `SFPS_ADDR_LOCK: begin
            if (pg_valid) begin
              lock_reg[cur] <= REG_WDATA; // RQ10
            end
          end
          default: begin
            // Other offsets have no storage here
          end
        endcase
      end
    end
  end

  // Fuse model: survives chip reset, bits can only be blown to one
  always @(posedge CLK_SYS) begin
    if (FUSE_BLANK) begin
      fuse_wake  <= `SFPS_RST_BYTE;
      fuse_ptr   <= `SFPS_RST_BYTE;
      sec_burned <= `SFPS_RST_BYTE;
    end else if (t_done && !SRST) begin
      sec_burned[burn_idx] <= 1'b1;     // RQ6
      if (burn_idx == 3'd0) begin
        // A second master burn may only add bits, e.g. bit 6
        fuse_wake <= fuse_wake | wake_sel;     // RQ5 RQ11
        fuse_ptr  <= fuse_ptr | fuse_ptr_reg;  // RQ3
      end
    end
  end

  // Status outputs, all registered
  always @(posedge CLK_SYS) begin
    if (SRST) begin
      STATE          <= ST_BOOT;
      BURN_BUSY      <= 1'b0;
      BURN_DONE      <= 1'b0;
      SEC_BURNED     <= `SFPS_RST_BYTE;
      SLAVE_SEC_SEL  <= 7'h00;
      SLAVE_FORCE_ON <= 7'h00;
      MANUAL_WAKE    <= 1'b0;
      SEC_BOOT       <= 1'b0;
    end else begin
      STATE      <= state;
      BURN_BUSY  <= t_busy;
      BURN_DONE  <= t_done;
      SEC_BURNED <= sec_burned;
      // Force power only where both force registers set the bit
      SLAVE_FORCE_ON <= force0[6:0] & force1[6:0]; // RQ9
      if (state == ST_BOOT) begin
        // Pointer is sampled from fuse at boot, never from live register
        SLAVE_SEC_SEL <= fuse_ptr[6:0];            // RQ3 RQ8
        MANUAL_WAKE   <= man_sel;                  // RQ4 RQ5
        SEC_BOOT      <= !man_sel && (fuse_ptr[6:0] == 7'h7f); // RQ12
      end
    end
  end

  // Read port: data one cycle after the strobe
  always @(posedge CLK_SYS) begin
    if (SRST) begin
      REG_RDATA  <= 8'h00;
      REG_RVALID <= 1'b0;
    end else begin
      REG_RVALID <= REG_RD;
      if (REG_RD) begin
        case (REG_ADDR)
          `SFPS_ADDR_PGM_CMD:  REG_RDATA <= {4'h0, sec_burned[cur] & pg_valid,
                                             t_busy, state};
          `SFPS_ADDR_WAKE_SEL: REG_RDATA <= on_master ? wake_sel : 8'h00;
          `SFPS_ADDR_PTR:      REG_RDATA <= on_master ? fuse_ptr_reg : 8'h00;
          `SFPS_ADDR_FORCE0:   REG_RDATA <= on_master ? force0 : 8'h00;
          `SFPS_ADDR_FORCE1:   REG_RDATA <= on_master ? force1 : 8'h00;
          `SFPS_ADDR_LOCK:     REG_RDATA <= pg_valid ? cur_lock : 8'h00;
          `SFPS_ADDR_PAGE:     REG_RDATA <= page;
          default:             REG_RDATA <= 8'h00; // Unmapped reads zero
        endcase
      end
    end
  end

endmodule

/* tb/sfps_seq_assertions.sv */
// Port checks for the secondary fuse sequencer
`timescale 1ns/1ps
module sfps_seq_chk #(
  parameter BURN_CYCLES = 20  // Burn length
) (
  input wire       CLK_SYS,        // Clock
  input wire       SRST,           // Reset
  input wire       FUSE_BLANK,     // Erase
  input wire       REG_WR,         // Write
  input wire [7:0] REG_ADDR,       // Offset
  input wire [1:0] STATE,          // State
  input wire       BURN_BUSY,      // Burning
  input wire       BURN_DONE,      // Burn end
  input wire [7:0] SEC_BURNED,     // Burned
  input wire [6:0] SLAVE_SEC_SEL,  // Pointers
  input wire [6:0] SLAVE_FORCE_ON, // Forced
  input wire       MANUAL_WAKE,    // Manual
  input wire       SEC_BOOT        // Auto
);
  reg [9:0] bcnt;  // Busy cycles
  reg [2:0] rcnt;  // Edges since reset
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (SRST);
  // Counting avoids a long repetition on the burn length
  always @(posedge CLK_SYS) begin
    bcnt <= BURN_BUSY ? bcnt + 10'h001 : 10'h000;
    rcnt <= SRST ? 3'h0 : rcnt + {2'h0, rcnt != 3'h7};
  end
  // Boot settled; end of a burn
  sequence boot_s; $fell(SRST) ##3 1'b1; endsequence
  sequence end_s; $fell(BURN_BUSY); endsequence
  boot_mode_a: assert property (boot_s |->
    STATE == (MANUAL_WAKE ? 2'd2 : 2'd1)) else $error("bad boot");
  burn_len_a: assert property (end_s |->
    bcnt == BURN_CYCLES) else $error("bad burn length");
  burn_end_a: assert property (end_s |->
    BURN_DONE ##1 !BURN_DONE && STATE == 2'd2) else $error("bad burn end");
  burn_gate_a: assert property ($rose(BURN_BUSY) |->
    STATE == 2'd3 && $past(STATE, 2) == 2'd2) else $error("burn gated");
  fuse_keep_a: assert property (!FUSE_BLANK && rcnt == 3'h7 |->
    ($past(SEC_BURNED) & ~SEC_BURNED) == 8'h00) else $error("fuse lost");
  ptr_hold_a: assert property (rcnt == 3'h7 |->
    $stable(SLAVE_SEC_SEL) && $stable(MANUAL_WAKE)) else $error("ptr moved");
  sec_boot_a: assert property (SEC_BOOT |->
    SLAVE_SEC_SEL == 7'h7f && !MANUAL_WAKE) else $error("bad auto boot");
  force_on_a: assert property ($rose(SLAVE_FORCE_ON == 7'h7f) |->
    $past(REG_WR, 2) && $past(REG_ADDR[7:1], 2) == 7'h70)
    else $error("force unasked");
endmodule
bind sfps_seq sfps_seq_chk #(.BURN_CYCLES(BURN_CYCLES)) i_sfps_seq_chk (
  .CLK_SYS(CLK_SYS), .SRST(SRST), .FUSE_BLANK(FUSE_BLANK), .REG_WR(REG_WR),
  .REG_ADDR(REG_ADDR), .STATE(STATE), .BURN_BUSY(BURN_BUSY),
  .BURN_DONE(BURN_DONE), .SEC_BURNED(SEC_BURNED),
  .SLAVE_SEC_SEL(SLAVE_SEC_SEL), .SLAVE_FORCE_ON(SLAVE_FORCE_ON),
  .MANUAL_WAKE(MANUAL_WAKE), .SEC_BOOT(SEC_BOOT));

/* tb/sfps_host.sv */
// Host model issuing paged register traffic
`timescale 1ns/1ps
module sfps_host (
  input  wire       clk,    // Clock
  output reg        wr,     // Write strobe
  output reg        rd,     // Read strobe
  output reg  [7:0] addr,   // Offset
  output reg  [7:0] wdata,  // Write data
  input  wire [7:0] rdata,  // Read data
  input  wire       rvalid  // Read valid
);
  // Quiet bus until the first request
  initial begin
    wr = 1'b0;
    rd = 1'b0;
    addr = 8'h00;
    wdata = 8'h00;
  end
  // One-cycle strobe, entered just after an edge; an idle edge follows so
  // back-to-back calls never drop and raise the strobe in one time step
  task w(input logic [7:0] a, input logic [7:0] d);
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(posedge clk) #1 wr = 1'b0;
    @(posedge clk) #1;
  endtask
  // Data is valid one edge after the strobe
  task r(input logic [7:0] a, output logic [7:0] d);
    addr = a;
    rd = 1'b1;
    @(posedge clk) #1 rd = 1'b0;
    d = rvalid ? rdata : 8'hxx;
  endtask
  // One-bit update; neighbours keep their contents
  task rmw(input logic [7:0] a, input int lsb, input logic [7:0] v);
    logic [7:0] d;
    r(a, d);
    w(a, (d & ~(8'h01 << lsb)) | ((v & 8'h01) << lsb));
  endtask
  // Escape pulse 00 / 02 / 00
  task esc;
    w(8'h0f, 8'h00);
    w(8'h0f, 8'h02);
    w(8'h0f, 8'h00);
  endtask
  // Burn pulse; the trailing 00 lands while burning
  task burn;
    w(8'h0f, 8'h00);
    w(8'h0f, 8'hc0);
    w(8'h0f, 8'h00);
  endtask
endmodule

/* tb/sfps_seq_tb.sv */
// Bench for the secondary fuse sequencer
`timescale 1ns/1ps
module sfps_seq_tb;
  localparam NB = 4;                     // Short burn
  logic       clk_sys, srst, fuse_blank; // Clock, reset, erase
  wire        wr, rd, rv, busy, done;    // Strobes, burn flags
  wire        man, sb;                   // Boot modes
  wire  [7:0] addr, wd, rdt, burned;     // Bus, fuse status
  wire  [1:0] st;                        // State
  wire  [6:0] ssel, fon;                 // Slave outputs
  int         mismatches = 0;            // Failures
  int         n_checks = 0;              // Comparisons
  int         cyc = 0;                   // Cycles run
  logic [7:0] d;                         // Read data
  sfps_host i_sfps_host (.clk(clk_sys), .wr(wr), .rd(rd), .addr(addr),
    .wdata(wd), .rdata(rdt), .rvalid(rv));
  sfps_seq #(.BURN_CYCLES(NB)) i_sfps_seq (.CLK_SYS(clk_sys), .SRST(srst),
    .FUSE_BLANK(fuse_blank), .REG_WR(wr), .REG_RD(rd), .REG_ADDR(addr),
    .REG_WDATA(wd), .REG_RDATA(rdt), .REG_RVALID(rv), .STATE(st),
    .BURN_BUSY(busy), .BURN_DONE(done), .SEC_BURNED(burned),
    .SLAVE_SEC_SEL(ssel), .SLAVE_FORCE_ON(fon), .MANUAL_WAKE(man),
    .SEC_BOOT(sb));
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  // Hang guard, far above the run's length
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      mismatches++;
      stop_test;
    end
  end
  task chk(input logic [7:0] g, input logic [7:0] e);
    n_checks++;
    if (g !== e) begin
      mismatches++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task stop_test;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task nap(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  // Fuse contents survive this reset
  task rst_dev;
    srst = 1'b1;
    nap(12);
    srst = 1'b0;
    fuse_blank = 1'b0;
    nap(6);
  endtask
  // Burn, then wait a bounded time for the done pulse
  task burn_wait;
    int i;
    i_sfps_host.burn;
    chk(busy, 1);
    for (i = 0; i < 40 && done !== 1'b1; i++)
      @(posedge clk_sys) #1;
    chk(done, 1);
    chk(busy, 0);
    nap(2);
  endtask
  // Blank part wakes active and refuses a burn there
  task t_boot;
    fuse_blank = 1'b1;
    rst_dev;
    chk(st, 1);
    chk(man, 0);
    i_sfps_host.burn;
    nap(NB + 8);
    chk(burned, 0);
    $display("t_boot done");
  endtask
  task t_master;
    i_sfps_host.esc;
    nap(2);
    chk(st, 2);
    i_sfps_host.w(8'h22, 8'hff);
    i_sfps_host.rmw(8'h10, 7, 1);
    i_sfps_host.r(8'h10, d);
    chk(d, 8'h80);
    burn_wait;
    chk(burned, 8'h01);
    chk(ssel, 0);
    $display("t_master done");
  endtask
  // Unlocked burn first, then every slave page in host order
  task t_slaves;
    logic [7:0] pg [7] = '{8'h02, 8'h01, 8'h03, 8'h0a, 8'h0b, 8'h0c, 8'h0d};
    logic [7:0] ex;
    int k;
    rst_dev;
    chk(ssel, 8'h7f);
    chk(st, 2);
    chk(man, 1);
    i_sfps_host.w(8'he0, 8'h7f);
    i_sfps_host.w(8'he1, 8'h7f);
    nap(1);
    chk(fon, 8'h7f);
    i_sfps_host.w(8'hff, 8'h02);
    i_sfps_host.burn;
    nap(NB + 8);
    chk(burned, 8'h01);
    ex = 8'h01;
    for (k = 0; k < 7; k++) begin
      i_sfps_host.w(8'hff, pg[k]);
      i_sfps_host.r(8'hff, d);
      chk(d, pg[k]);
      i_sfps_host.w(8'h2f, 8'h40);
      burn_wait;
      ex = ex | (8'h01 << (pg[k] > 8'h03 ? pg[k] - 8'h06 : pg[k]));
      chk(burned, ex);
    end
    $display("t_slaves done");
  endtask
  task t_finish;
    i_sfps_host.w(8'hff, 8'h00);
    i_sfps_host.esc;
    i_sfps_host.rmw(8'h10, 6, 1);
    i_sfps_host.r(8'h10, d);
    chk(d, 8'hc0);
    burn_wait;
    rst_dev;
    chk(sb, 1);
    chk(man, 0);
    chk(st, 1);
    $display("t_finish done");
  endtask
  initial begin
    t_boot;
    t_master;
    t_slaves;
    t_finish;
    stop_test;
  end
endmodule
